/* design/uaf_autoflow.sv */
// auto-rts / auto-cts flow control for one uart channel
//////////////////////////////////////////////////////////////////////////////
// What this block does
// - with auto-cts on, a byte starts only while clear-to-send is active
// - trigger 1, 4 or 8 with auto-rts: drop rts when fill reaches trigger
// - one more byte after rts drops is still accepted into the fifo
// - trigger 1, 4 or 8: raise rts again once reads empty the fifo
// - trigger 14: drop rts when sixteenth character's first data bit arrives
// - trigger 14: raise rts if one free and idle, or more than one free
// - trigger 14, fifo full: the first buffer read raises rts again when no character is arriving
// - receive fifo holds sixteen, full when the sixteenth byte completes
// - cts dropped before last stop bit midpoint withholds the next byte
// - cts returning active lets a held transmitter resume
// - cts level changes raise no interrupt while flow control is on
// - without auto-cts every queued byte is sent regardless of cts
// - autoflow bit and rts bit both set give auto-rts plus auto-cts
// - autoflow bit set with rts bit clear gives auto-cts only
// - trigger level selectable among 1, 4, 8 and 14 bytes
//////////////////////////////////////////////////////////////////////////////
`timescale 1ns/1ps
module uaf_autoflow #(
   parameter int RX_DEPTH = uaf_pkg::RX_DEPTH,
   parameter int TX_DEPTH = uaf_pkg::TX_DEPTH
) (
   input wire logic clk,
   input wire logic rst_n,
   input wire logic autoflow_enable_bit,
   input wire logic modem_rts_bit,
   input wire logic [1:0] trig_sel,
   input wire logic cts_n,
   output logic rts_n,
   output logic cts_change_irq,
   input wire logic host_tx_valid,
   input wire logic [uaf_pkg::DATA_W-1:0] host_tx_data,
   output logic host_tx_ready,
   output logic tx_start,
   output logic [uaf_pkg::DATA_W-1:0] tx_byte,
   input wire logic tx_stop_mid,
   input wire logic rx_first_bit,
   input wire logic rx_done,
   input wire logic [uaf_pkg::DATA_W-1:0] rx_data,
   input wire logic rd_req,
   output logic rd_valid,
   output logic [uaf_pkg::DATA_W-1:0] rd_data,
   output logic rx_overrun
);
   localparam int CW = $clog2(RX_DEPTH + 1);
   localparam int TCW = $clog2(TX_DEPTH + 1);
   if (RX_DEPTH != 16) begin : g_chk_rx
      $error("uaf_autoflow: trigger 14 timing needs a 16 deep receive fifo");
   end
   if (TX_DEPTH < 2) begin : g_chk_tx
      $error("uaf_autoflow: transmit fifo too shallow");
   end

   typedef struct packed {
      uaf_pkg::uaf_tx_st_t tx_st;
      logic rts;
      logic rx_busy;
      logic cts_q;
      logic dcts;
      logic tx_start;
      logic [uaf_pkg::DATA_W-1:0] tx_byte;
      logic rd_valid;
      logic [uaf_pkg::DATA_W-1:0] rd_data;
      logic ovr;
      logic host_ready;
   } uaf_st_t;
   uaf_st_t s_reg;
   uaf_st_t s_next;

   logic auto_cts;
   logic auto_rts;
   logic cts_act;
   logic trig14;
   logic [CW-1:0] trig_lvl;
   logic rxq_ready;
   logic rxq_valid;
   logic [uaf_pkg::DATA_W-1:0] rxq_data;
   logic [CW-1:0] rx_cnt;
   logic [CW-1:0] cnt_n;
   logic [CW-1:0] free_n;
   logic rx_push;
   logic rx_pop;
   logic txq_in_ready;
   logic txq_valid;
   logic [uaf_pkg::DATA_W-1:0] txq_data;
   logic tx_pop;
   logic [TCW-1:0] tx_cnt;

   //////////////////////////////////////////////////////////////////////////
   assign auto_cts = autoflow_enable_bit;
   assign auto_rts = autoflow_enable_bit && modem_rts_bit;
   assign cts_act = !cts_n;
   assign trig14 = (trig_sel == uaf_pkg::TRIG_SEL_14);

   always_comb begin
      case (trig_sel)
         uaf_pkg::TRIG_SEL_1: trig_lvl = CW'(uaf_pkg::TRIG_LVL_1);
         uaf_pkg::TRIG_SEL_4: trig_lvl = CW'(uaf_pkg::TRIG_LVL_4);
         uaf_pkg::TRIG_SEL_8: trig_lvl = CW'(uaf_pkg::TRIG_LVL_8);
         default: trig_lvl = CW'(RX_DEPTH);
      endcase
   end

   // receive fifo fills until truly full, so the byte in flight after rts drops still lands
   uaf_fifo #(.WIDTH(uaf_pkg::DATA_W), .DEPTH(RX_DEPTH)) u_rxq (
      .clk(clk),
      .rst_n(rst_n),
      .in_valid(rx_done),
      .in_ready(rxq_ready),
      .in_data(rx_data),
      .out_valid(rxq_valid),
      .out_ready(rd_req),
      .out_data(rxq_data),
      .count(rx_cnt)
   );

   // the stall on the filling side reaches the host through host_tx_ready
   uaf_fifo #(.WIDTH(uaf_pkg::DATA_W), .DEPTH(TX_DEPTH)) u_txq (
      .clk(clk),
      .rst_n(rst_n),
      .in_valid(host_tx_valid),
      .in_ready(txq_in_ready),
      .in_data(host_tx_data),
      .out_valid(txq_valid),
      .out_ready(tx_pop),
      .out_data(txq_data),
      .count(tx_cnt)
   );

   assign rx_push = rx_done && rxq_ready;
   assign rx_pop = rd_req && rxq_valid;
   assign cnt_n = rx_cnt + CW'(rx_push) - CW'(rx_pop);
   assign free_n = CW'(RX_DEPTH) - cnt_n;
   assign tx_pop = s_next.tx_start;

   //////////////////////////////////////////////////////////////////////////
   always_comb begin
      s_next = s_reg;
      s_next.tx_start = 1'b0;
      s_next.rd_valid = 1'b0;
      s_next.dcts = 1'b0;
      s_next.cts_q = cts_n;
      s_next.ovr = rx_done && !rxq_ready;
      // host_ready is one cycle late; pessimistic by one so the fifo is never overfilled
      s_next.host_ready = (tx_cnt + TCW'(host_tx_valid && txq_in_ready)) < TCW'(TX_DEPTH - 1);

      // modem status delta is only reported with flow control off
      if (!autoflow_enable_bit && (cts_n != s_reg.cts_q)) begin
         s_next.dcts = 1'b1;
      end

      if (rx_first_bit) begin
         s_next.rx_busy = 1'b1;
      end else if (rx_done) begin
         s_next.rx_busy = 1'b0;
      end

      if (rx_pop) begin
         s_next.rd_valid = 1'b1;
         s_next.rd_data = rxq_data;
      end

      // rts
      if (!auto_rts) begin
         s_next.rts = modem_rts_bit;
      end else if (trig14) begin
         // full: a read frees one slot with nothing in flight, so rts comes back
         s_next.rts = (free_n > CW'(1)) ||
                      ((free_n == CW'(1)) && !s_next.rx_busy);
      end else if (cnt_n >= trig_lvl) begin
         s_next.rts = 1'b0;
      end else if (cnt_n == '0) begin
         s_next.rts = 1'b1;
      end

      // transmitter gate, checked once per byte boundary
      case (s_reg.tx_st)
         uaf_pkg::TX_IDLE: begin
            if (txq_valid && (!auto_cts || cts_act)) begin
               s_next.tx_start = 1'b1;
               s_next.tx_byte = txq_data;
               s_next.tx_st = uaf_pkg::TX_SEND;
            end
         end
         uaf_pkg::TX_SEND: begin
            if (tx_stop_mid) begin
               s_next.tx_st = (auto_cts && !cts_act) ? uaf_pkg::TX_HOLD
                                                     : uaf_pkg::TX_IDLE;
            end
         end
         uaf_pkg::TX_HOLD: begin
            if (!auto_cts || cts_act) begin
               s_next.tx_st = uaf_pkg::TX_IDLE;
               if (txq_valid) begin
                  s_next.tx_start = 1'b1;
                  s_next.tx_byte = txq_data;
                  s_next.tx_st = uaf_pkg::TX_SEND;
               end
            end
         end
         default: s_next.tx_st = uaf_pkg::TX_IDLE;
      endcase
   end

   always_ff @(posedge clk) begin
      if (!rst_n) begin
         s_reg <= '0;
         s_reg.tx_st <= uaf_pkg::TX_IDLE;
         s_reg.rts <= uaf_pkg::RTS_RESET;
         s_reg.cts_q <= 1'b1;
         s_reg.host_ready <= 1'b1;
      end else begin
         s_reg <= s_next;
      end
   end

   assign rts_n = !s_reg.rts;
   assign cts_change_irq = s_reg.dcts;
   assign host_tx_ready = s_reg.host_ready;
   assign tx_start = s_reg.tx_start;
   assign tx_byte = s_reg.tx_byte;
   assign rd_valid = s_reg.rd_valid;
   assign rd_data = s_reg.rd_data;
   assign rx_overrun = s_reg.ovr;

   //////////////////////////////////////////////////////////////////////////
   default clocking cb @(posedge clk);
   endclocking
   default disable iff (!rst_n);

   cts_gate_a: assert property (tx_start |-> (!$past(autoflow_enable_bit) || !$past(cts_n)))
      else $error("byte started while cts inactive");
   trig_drop_a: assert property (($past(auto_rts) && !$past(trig14)
         && (rx_cnt >= $past(trig_lvl))) |-> !s_reg.rts)
      else $error("rts still active at trigger level");
   // the first edge after reset still shows the reset rts value, so it is skipped
   empty_raise_a: assert property (($past(rst_n) && $past(auto_rts) && !$past(trig14)
         && (rx_cnt == '0)) |-> s_reg.rts)
      else $error("rts not raised on empty fifo");
   sixteenth_drop_a: assert property (($past(auto_rts) && $past(trig14)
         && $past(rx_first_bit) && (rx_cnt == CW'(RX_DEPTH - 1))) |-> !s_reg.rts)
      else $error("rts not dropped on sixteenth character");
   space_raise_a: assert property (($past(rst_n) && $past(auto_rts) && $past(trig14)
         && (rx_cnt < CW'(RX_DEPTH - 1))) |-> s_reg.rts)
      else $error("rts not raised with room in fifo");
   full_read_a: assert property ((auto_rts && trig14 && (rx_cnt == CW'(RX_DEPTH))
         && rd_req && !rx_done && !rx_first_bit && !s_reg.rx_busy) |=> s_reg.rts)
      else $error("read of full fifo did not raise rts");
   full_mark_a: assert property ((rx_cnt == CW'(RX_DEPTH - 1) && rx_done && !rd_req)
         |=> (rx_cnt == CW'(RX_DEPTH)) and (rx_done |=> rx_overrun))
      else $error("fifo not full after sixteenth byte");
   stop_hold_a: assert property ((s_reg.tx_st == uaf_pkg::TX_SEND && tx_stop_mid
         && autoflow_enable_bit && cts_n)
         |=> (s_reg.tx_st == uaf_pkg::TX_HOLD) ##1 (!tx_start || !$past(cts_n)))
      else $error("next byte sent after cts dropped");
   resume_a: assert property ((s_reg.tx_st == uaf_pkg::TX_HOLD && !cts_n && txq_valid)
         |=> tx_start)
      else $error("held transmitter did not resume");
   no_irq_a: assert property (autoflow_enable_bit |=> !cts_change_irq)
      else $error("cts change interrupt with flow control on");
   free_send_a: assert property ((s_reg.tx_st == uaf_pkg::TX_IDLE && txq_valid
         && !autoflow_enable_bit) |=> tx_start)
      else $error("queued byte not sent without auto-cts");

   rts_cycle_c: cover property ($fell(s_reg.rts) ##[1:200] $rose(s_reg.rts));
   cts_hold_c: cover property (s_reg.tx_st == uaf_pkg::TX_HOLD ##[1:100] tx_start);
   rx_full_c: cover property (rx_cnt == CW'(RX_DEPTH));
endmodule

/* design/uaf_pkg.sv */
// constants shared by the autoflow control block and its testbench
package uaf_pkg;
   localparam int DATA_W = 8;
   localparam int RX_DEPTH = 16;
   localparam int TX_DEPTH = 8;
   // receive trigger level select codes
   localparam logic [1:0] TRIG_SEL_1 = 2'h0;
   localparam logic [1:0] TRIG_SEL_4 = 2'h1;
   localparam logic [1:0] TRIG_SEL_8 = 2'h2;
   localparam logic [1:0] TRIG_SEL_14 = 2'h3;
   localparam int TRIG_LVL_1 = 1;
   localparam int TRIG_LVL_4 = 4;
   localparam int TRIG_LVL_8 = 8;
   localparam logic RTS_RESET = 1'b0;
   typedef enum logic [1:0] {TX_IDLE, TX_SEND, TX_HOLD} uaf_tx_st_t;
endpackage

/* design/uaf_fifo.sv */
// flip-flop fifo with valid/ready on both sides and a fill count
`timescale 1ns/1ps
module uaf_fifo #(
   parameter int WIDTH = 8,
   parameter int DEPTH = 8
) (
   input wire logic clk,
   input wire logic rst_n,
   input wire logic in_valid,
   output logic in_ready,
   input wire logic [WIDTH-1:0] in_data,
   output logic out_valid,
   input wire logic out_ready,
   output logic [WIDTH-1:0] out_data,
   output logic [$clog2(DEPTH+1)-1:0] count
);
   localparam int AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
   localparam int CW = $clog2(DEPTH + 1);
   if (DEPTH < 2) begin : g_chk
      $error("uaf_fifo needs DEPTH of at least 2");
   end
   typedef struct packed {
      logic [DEPTH-1:0][WIDTH-1:0] mem;
      logic [AW-1:0] wr_ptr;
      logic [AW-1:0] rd_ptr;
      logic [CW-1:0] cnt;
      logic full;
      logic empty;
   } uaf_fifo_st_t;
   uaf_fifo_st_t s_reg;
   uaf_fifo_st_t s_next;
   logic push;
   logic pop;

   assign in_ready = !s_reg.full;
   assign out_valid = !s_reg.empty;
   assign out_data = s_reg.mem[s_reg.rd_ptr];
   assign count = s_reg.cnt;
   assign push = in_valid && !s_reg.full;
   assign pop = out_ready && !s_reg.empty;

   always_comb begin
      s_next = s_reg;
      if (push) begin
         s_next.mem[s_reg.wr_ptr] = in_data;
         s_next.wr_ptr = (s_reg.wr_ptr == AW'(DEPTH - 1)) ? '0 : s_reg.wr_ptr + 1'b1;
      end
      if (pop) begin
         s_next.rd_ptr = (s_reg.rd_ptr == AW'(DEPTH - 1)) ? '0 : s_reg.rd_ptr + 1'b1;
      end
      s_next.cnt = s_reg.cnt + CW'(push) - CW'(pop);
      s_next.full = (s_next.cnt == CW'(DEPTH));
      s_next.empty = (s_next.cnt == '0);
   end

   always_ff @(posedge clk) begin
      if (!rst_n) begin
         s_reg <= '0;
         s_reg.empty <= 1'b1;
      end else begin
         s_reg <= s_next;
      end
   end
endmodule

/* verification/uaf_remote.sv */
// far-side uart model: framer stop-bit timing plus an rts-aware sender
`timescale 1ns/1ps
//////////////////////////////////////////////////
module uaf_remote #(
   parameter int BIT_T = 4
) (
   input wire logic clk,
   input wire logic rst_n,
   input wire logic tx_start,
   output logic tx_stop_mid,
   input wire logic rts_n,
   input wire logic send,
   input wire logic ignore_rts,
   input wire logic [7:0] send_data,
   output logic rx_first_bit,
   output logic rx_done,
   output logic [7:0] rx_data,
   output logic busy
);
   int tc;
   int rc;
   assign busy = (rc != 0);
   always @(posedge clk) begin
      tx_stop_mid <= 1'b0;
      rx_first_bit <= 1'b0;
      rx_done <= 1'b0;
      if (!rst_n) begin
         tc <= 0;
         rc <= 0;
         rx_data <= 8'hff;
      end else begin
         // stop-bit midpoint lands a whole frame after each start
         if (tx_start) tc <= 10 * BIT_T;
         else if (tc > 0) tc <= tc - 1;
         if (tc == 1) tx_stop_mid <= 1'b1;
         // rts is only checked before a byte, so one late byte may slip
         if (rc == 0 && send && (!rts_n || ignore_rts)) begin
            rc <= BIT_T;
            rx_first_bit <= 1'b1;
         end else if (rc > 0) rc <= rc - 1;
         // data is only meaningful with the done strobe; it churns otherwise
         rx_data <= (rc == 1) ? send_data : ~rx_data;
         if (rc == 1) rx_done <= 1'b1;
      end
   end
endmodule

/* verification/tb.sv */
// self-checking bench for the autoflow control block
`timescale 1ns/1ps
//////////////////////////////////////////////////
module tb;
   logic clk = 0, rst_n = 0, af_en = 0, rts_bit = 0, cts_n = 1, tx_v = 0, rd_req = 0;
   logic send = 0, ign = 0;
   logic [1:0] trig = 0;
   logic [7:0] tx_d = 0, sd = 0, tx_byte, rx_data, rd_data;
   logic rts_n, irq, tx_rdy, tx_start, stop_mid, first_bit, rx_done, rd_valid, ovr, busy;
   int n_fail = 0, compares = 0, cycles = 0, n_start = 0, n_irq = 0, n_ovr = 0;
   initial forever #4 clk = ~clk;
   uaf_autoflow u_uaf_autoflow (.clk(clk), .rst_n(rst_n), .autoflow_enable_bit(af_en),
      .modem_rts_bit(rts_bit), .trig_sel(trig), .cts_n(cts_n), .rts_n(rts_n),
      .cts_change_irq(irq),
      .host_tx_valid(tx_v), .host_tx_data(tx_d), .host_tx_ready(tx_rdy), .tx_start(tx_start),
      .tx_byte(tx_byte), .tx_stop_mid(stop_mid), .rx_first_bit(first_bit), .rx_done(rx_done),
      .rx_data(rx_data), .rd_req(rd_req), .rd_valid(rd_valid), .rd_data(rd_data),
      .rx_overrun(ovr));
   uaf_remote u_uaf_remote (.clk(clk), .rst_n(rst_n), .tx_start(tx_start),
      .tx_stop_mid(stop_mid), .rts_n(rts_n), .send(send), .ignore_rts(ign), .send_data(sd),
      .rx_first_bit(first_bit), .rx_done(rx_done), .rx_data(rx_data), .busy(busy));
   always @(posedge clk) begin
      cycles++;
      n_start += int'(tx_start === 1'b1);
      n_irq += int'(irq === 1'b1);
      n_ovr += int'(ovr === 1'b1);
      if (cycles == 5000) begin
         n_fail++;
         end_sim();
      end
   end
   //////////////////////////////////////////////////
   task automatic end_sim();
      $display("compares %0d n_fail %0d", compares, n_fail);
      if (n_fail == 0 && compares > 0) $display("No errors found");
      else $display("Errors were found");
      $finish;
   endtask
   task automatic cyc(input int n);
      repeat (n) @(negedge clk);
   endtask
   task automatic chk(input logic [7:0] got, input logic [7:0] exp, input string m);
      compares++;
      if (got !== exp) begin
         n_fail++;
         $display("MISMATCH %0t %s", $time, m);
      end
   endtask
   task automatic restart(input logic a, input logic m, input logic [1:0] t);
      rst_n = 0;
      af_en = a;
      rts_bit = m;
      trig = t;
      cyc(2);
      rst_n = 1;
      n_start = 0;
      n_irq = 0;
      n_ovr = 0;
      cyc(2);
   endtask
   task automatic put(input logic [7:0] d, input logic i, input int w);
      sd = d;
      ign = i;
      send = 1;
      cyc(1);
      send = 0;
      cyc(w);
   endtask
   task automatic rd(input logic [7:0] e);
      rd_req = 1;
      cyc(1);
      rd_req = 0;
      chk(rd_valid, 8'h01, "read strobe");
      chk(rd_data, e, "read data order");
      cyc(1);
   endtask
   task automatic wr(input logic [7:0] d);
      tx_d = d;
      tx_v = 1;
      cyc(1);
      tx_v = 0;
      cyc(1);
   endtask
   //////////////////////////////////////////////////
   task automatic t_modes();
      chk(rts_n, 8'h01, "rts inactive high after reset");
      chk(rd_valid, 8'h00, "no read strobe after reset");
      restart(1, 0, 0);
      chk(rts_n, 8'h01, "rts stays off with only auto-cts");
      restart(1, 1, 0);
      chk(rts_n, 8'h00, "rts asserted low with autoflow, empty");
   endtask
   task automatic t_trig(input logic [1:0] t, input int n);
      restart(1, 1, t);
      for (int i = 0; i < n; i++) begin
         chk(rts_n, 8'h00, "rts on below trigger");
         put(8'(8'h10 + i), 0, 7);
      end
      chk(rts_n, 8'h01, "rts off at trigger");
      put(8'(8'h10 + n), 1, 7);
      for (int i = 0; i <= n; i++) begin
         chk(rts_n, 8'h01, "rts held while not empty");
         rd(8'(8'h10 + i));
      end
      chk(rts_n, 8'h00, "rts back once empty");
   endtask
   task automatic t_full();
      restart(1, 1, uaf_pkg::TRIG_SEL_14);
      for (int i = 0; i < 15; i++) put(8'(i), 0, 7);
      chk(rts_n, 8'h00, "rts on with one free and idle");
      put(8'h0f, 0, 2);
      chk(busy, 8'h01, "sixteenth char still arriving");
      chk(rts_n, 8'h01, "rts off at sixteenth first bit");
      cyc(5);
      put(8'hee, 1, 7);
      chk(8'(n_ovr), 8'h01, "full after sixteen");
      rd(8'h00);
      chk(rts_n, 8'h00, "first read of full fifo restores rts");
   endtask
   task automatic t_cts();
      cts_n = 1;
      restart(1, 1, 0);
      wr(8'ha1);
      cyc(20);
      chk(8'(n_start), 8'h00, "held while cts off");
      cts_n = 0;
      cyc(3);
      chk(8'(n_start), 8'h01, "start once cts on");
      chk(tx_byte, 8'ha1, "first byte");
      wr(8'hb2);
      cyc(10);
      cts_n = 1;
      cyc(60);
      chk(8'(n_start), 8'h01, "next byte withheld");
      chk(8'(n_irq), 8'h00, "no cts interrupt under autoflow");
      cts_n = 0;
      cyc(3);
      chk(8'(n_start), 8'h02, "resume after cts back");
      chk(tx_byte, 8'hb2, "second byte");
   endtask
   // auto-cts alone holds the queue, so the write side must stall one entry early
   task automatic t_txfull();
      cts_n = 1;
      restart(1, 0, 0);
      for (int i = 0; i < uaf_pkg::TX_DEPTH - 2; i++) wr(8'(i));
      chk(tx_rdy, 8'h01, "room left below the early stop");
      wr(8'h7e);
      chk(tx_rdy, 8'h00, "write side stalls one entry early");
      chk(8'(n_start), 8'h00, "auto-cts alone holds the queue");
   endtask
   task automatic t_plain();
      cts_n = 1;
      restart(0, 1, 0);
      wr(8'hc3);
      cyc(4);
      chk(8'(n_start), 8'h01, "sent regardless of cts");
      chk(tx_byte, 8'hc3, "plain byte");
      cts_n = 0;
      cyc(3);
      chk(8'(n_irq), 8'h01, "cts interrupt without autoflow");
   endtask
   //////////////////////////////////////////////////
   initial begin
      cyc(20);
      rst_n = 1;
      cyc(1);
      t_modes();
      t_trig(uaf_pkg::TRIG_SEL_1, uaf_pkg::TRIG_LVL_1);
      t_trig(uaf_pkg::TRIG_SEL_4, uaf_pkg::TRIG_LVL_4);
      t_trig(uaf_pkg::TRIG_SEL_8, uaf_pkg::TRIG_LVL_8);
      t_full();
      t_cts();
      t_txfull();
      t_plain();
      end_sim();
   end
endmodule
